/* File: core/dam_pkg.sv */
// dam_pkg: constants and types for the request address mapper
// Notes on behaviour
// - newer bank-top order: column lowest, then row, bank, group above
// - rank reads zero with one rank, else taken above every other field
// - older column-low order: column, bank, row, rank from the bottom up
// - newer column-low order: column, bank, group, row, logical rank, rank
// - newer linear interleave: bits 4:3 pick the group machine, row on top
// - stacked low: group at 3, bank, logical rank, upper column, row, rank
// - stacked mid: group at 3, bank, upper column, logical rank, row, rank
// - older half-bank interleave swaps the low bank bit with a column bit
// - x16 half-bank interleave: group at 3, bank split two bits apart
// - half-bank interleave: each run of eight covers four banks, next run next four
// - base-plus-width selects ascend from base; concatenations are msb first
// - three lowest request bits play no part in ordering; step is eight
// - an order select setting picks which mapping scheme applies
package dam_pkg;
	// request address and field widths
	localparam int DAM_ADDR_W = 32;
	localparam int DAM_COL_W = 10;
	localparam int DAM_ROW3_W = 16;
	localparam int DAM_BANK3_W = 3;
	localparam int DAM_ROW4_W = 15;
	localparam int DAM_BANK4_W = 2;
	localparam int DAM_GRP4_W = 2;
	localparam int DAM_GRP16_W = 1;
	localparam int DAM_LR_W = 1;
	localparam int DAM_RANK_W = 1;
	localparam int DAM_BURST_W = 3;
	localparam int DAM_RUN_W = 8;
	// register byte offsets
	localparam logic [4:0] DAM_REG_CTRL = 5'h00;
	localparam logic [4:0] DAM_REG_REQ = 5'h04;
	localparam logic [4:0] DAM_REG_ROW = 5'h08;
	localparam logic [4:0] DAM_REG_COL = 5'h0C;
	localparam logic [4:0] DAM_REG_FLD = 5'h10;
	localparam logic [4:0] DAM_REG_STAT = 5'h14;
	// control field positions and reset value
	localparam int DAM_CTRL_W = 6;
	localparam int DAM_CTRL_RANKS = 4;
	localparam int DAM_CTRL_STACK = 5;
	localparam logic [5:0] DAM_CTRL_RST = 6'h04;
	// packed field register positions
	localparam int DAM_FLD_GRP = 4;
	localparam int DAM_FLD_LR = 8;
	localparam int DAM_FLD_RANK = 12;
	typedef enum logic [3:0] {
		DAM_D3_LIN = 4'h0,
		DAM_D3_BRC = 4'h1,
		DAM_D3_RBC = 4'h2,
		DAM_D3_HBI = 4'h3,
		DAM_D4_LIN = 4'h4,
		DAM_D4_BRC = 4'h5,
		DAM_D4_RBC = 4'h6,
		DAM_D4_SDL = 4'h7,
		DAM_D4_SDM = 4'h8,
		DAM_D4_HBI16 = 4'h9,
		DAM_D4_HBI8 = 4'hA
	} dam_order_t;
	typedef struct packed {
		logic [15:0] row;
		logic [9:0] col;
		logic [2:0] bank;
		logic [1:0] grp;
		logic lr;
		logic rank;
	} dam_fields_t;
endpackage

/* File: core/dam_mapper.sv */
// dam_mapper: request address splitter with an Avalon-MM register port
`timescale 1ns/1ps
module dam_mapper (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// register bus
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// decoded fields
	output logic [15:0] rowOut,
	output logic [dam_pkg::DAM_COL_W-1:0] colOut,
	output logic [2:0] bankOut,
	output logic [1:0] groupOut,
	output logic lrankOut,
	output logic rankOut,
	output logic decValid
);
	import dam_pkg::*;

	localparam int C = DAM_COL_W;
	localparam int D3RK = DAM_BANK3_W + C + DAM_ROW3_W;
	localparam int D4LR = C + DAM_ROW4_W + DAM_BANK4_W + DAM_GRP4_W;
	localparam int SD = 3 + DAM_BANK4_W + DAM_GRP4_W;

	// one request address into all fields; widths fixed at elaboration
	function automatic dam_fields_t mapAddr(
		input logic [31:0] a,
		input logic [3:0] ord,
		input logic twoRk,
		input logic stk
	);
		dam_fields_t f;
		f = '0;
		case (ord)
			DAM_D3_LIN: begin
				f.bank = {a[3 +: DAM_BANK3_W-1], a[2+DAM_BANK3_W]};
				f.col = {a[3+DAM_BANK3_W +: C-3], a[2:0]};
				f.row = a[DAM_BANK3_W+C +: DAM_ROW3_W];
				f.rank = a[D3RK];
			end
			DAM_D3_BRC: begin
				f.col = a[0 +: C];
				f.row = a[C +: DAM_ROW3_W];
				f.bank = a[C+DAM_ROW3_W +: DAM_BANK3_W];
				f.rank = a[D3RK];
			end
			DAM_D3_RBC: begin
				f.col = a[0 +: C];
				f.bank = a[C +: DAM_BANK3_W];
				f.row = a[C+DAM_BANK3_W +: DAM_ROW3_W];
				f.rank = a[D3RK];
			end
			DAM_D3_HBI: begin
				f.bank = {a[3 +: DAM_BANK3_W-1], a[3+DAM_BANK3_W]};
				f.col = {a[4+DAM_BANK3_W +: C-4], a[2+DAM_BANK3_W], a[2:0]};
				f.row = a[DAM_BANK3_W+C +: DAM_ROW3_W];
				f.rank = a[D3RK];
			end
			DAM_D4_LIN: begin
				f.grp = a[3 +: DAM_GRP4_W];
				f.bank[1:0] = a[3+DAM_GRP4_W +: DAM_BANK4_W];
				f.col = {a[3+DAM_GRP4_W+DAM_BANK4_W +: C-3], a[2:0]};
				f.row[14:0] = a[DAM_GRP4_W+DAM_BANK4_W+C +: DAM_ROW4_W];
				f.lr = a[D4LR];
				f.rank = stk ? a[D4LR+DAM_LR_W] : a[D4LR];
			end
			DAM_D4_BRC: begin
				f.col = a[0 +: C];
				f.row[14:0] = a[C +: DAM_ROW4_W];
				f.bank[1:0] = a[C+DAM_ROW4_W +: DAM_BANK4_W];
				f.grp = a[C+DAM_ROW4_W+DAM_BANK4_W +: DAM_GRP4_W];
				f.lr = a[D4LR];
				f.rank = stk ? a[D4LR+DAM_LR_W] : a[D4LR];
			end
			DAM_D4_RBC: begin
				f.col = a[0 +: C];
				f.bank[1:0] = a[C +: DAM_BANK4_W];
				f.grp = a[C+DAM_BANK4_W +: DAM_GRP4_W];
				f.row[14:0] = a[C+DAM_BANK4_W+DAM_GRP4_W +: DAM_ROW4_W];
				f.lr = a[D4LR];
				f.rank = stk ? a[D4LR+DAM_LR_W] : a[D4LR];
			end
			DAM_D4_SDL: begin
				f.grp = a[3 +: DAM_GRP4_W];
				f.bank[1:0] = a[3+DAM_GRP4_W +: DAM_BANK4_W];
				f.lr = a[SD];
				f.col = {a[SD+DAM_LR_W +: C-3], a[2:0]};
				f.row[14:0] = a[SD-3+DAM_LR_W+C +: DAM_ROW4_W];
				f.rank = a[D4LR+DAM_LR_W];
			end
			DAM_D4_SDM: begin
				f.grp = a[3 +: DAM_GRP4_W];
				f.bank[1:0] = a[3+DAM_GRP4_W +: DAM_BANK4_W];
				f.col = {a[SD +: C-3], a[2:0]};
				f.lr = a[SD-3+C];
				f.row[14:0] = a[SD-3+C+DAM_LR_W +: DAM_ROW4_W];
				f.rank = a[D4LR+DAM_LR_W];
			end
			DAM_D4_HBI16: begin
				f.grp[0] = a[3];
				f.bank[1:0] = {a[5+DAM_GRP16_W], a[3+DAM_GRP16_W]};
				f.col = {a[4+DAM_GRP16_W+DAM_BANK4_W +: C-4], a[4+DAM_GRP16_W], a[2:0]};
				f.row[14:0] = a[DAM_GRP16_W+DAM_BANK4_W+C +: DAM_ROW4_W];
				f.rank = a[D4LR-1];
			end
			DAM_D4_HBI8: begin
				f.grp = a[3 +: DAM_GRP4_W];
				f.bank[1:0] = a[4+DAM_GRP4_W +: DAM_BANK4_W];
				f.col = {a[4+DAM_GRP4_W+DAM_BANK4_W +: C-4], a[3+DAM_GRP4_W], a[2:0]};
				f.row[14:0] = a[DAM_GRP4_W+DAM_BANK4_W+C +: DAM_ROW4_W];
				f.rank = a[D4LR];
			end
			default: begin
				f = '0;
			end
		endcase
		// fields that the configuration does not have read as zero
		if (!twoRk) begin
			f.rank = 1'b0;
		end
		if (!stk) begin
			f.lr = 1'b0;
		end
		return f;
	endfunction

	logic [DAM_CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [31:0] reqAddr_q, reqAddr_d;
	logic [31:0] readData_q, readData_d;
	logic waitReq_q, waitReq_d;
	dam_fields_t fld_q, fld_d;
	logic decValid_q, decValid_d;
	logic [DAM_RUN_W-1:0] run_q, run_d;
	logic [31:0] beMask;
	logic [31:0] rdMux;
	logic req;
	logic acc;
	logic [31:0] newAddr;
	logic stepHit;

	assign req = avs_read | avs_write;
	assign acc = req & ~waitReq_q;
	assign beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign newAddr = (reqAddr_q & ~beMask) | (avs_writedata & beMask);
	// low three bits stay out of the step test, so a step of eight is a run
	assign stepHit = newAddr[31:DAM_BURST_W] == reqAddr_q[31:DAM_BURST_W] + 29'h1;

	// read multiplexer; unmapped offsets read as zero
	always_comb begin
		case (avs_address)
			DAM_REG_CTRL: rdMux = {26'h0, ctrl_q};
			DAM_REG_REQ: rdMux = reqAddr_q;
			DAM_REG_ROW: rdMux = {16'h0, fld_q.row};
			DAM_REG_COL: rdMux = {22'h0, fld_q.col};
			DAM_REG_FLD: rdMux = {19'h0, fld_q.rank, 3'h0, fld_q.lr, 2'h0,
				fld_q.grp, 1'h0, fld_q.bank};
			DAM_REG_STAT: rdMux = {24'h0, run_q};
			default: rdMux = 32'h0;
		endcase
	end

	// bus answer and register next values
	always_comb begin
		// one wait cycle per access keeps readdata a plain flop
		waitReq_d = ~(req & waitReq_q);
		readData_d = readData_q;
		ctrl_d = ctrl_q;
		reqAddr_d = reqAddr_q;
		fld_d = fld_q;
		run_d = run_q;
		decValid_d = 1'b0;
		if (avs_read && waitReq_q) begin
			readData_d = rdMux;
		end
		if (acc && avs_write) begin
			case (avs_address)
				DAM_REG_CTRL: begin
					ctrl_d = (ctrl_q & ~beMask[5:0]) | (avs_writedata[5:0] & beMask[5:0]);
				end
				DAM_REG_REQ: begin
					reqAddr_d = newAddr;
					// decode in the accept cycle, fields stand from the next
					fld_d = mapAddr(newAddr, ctrl_q[3:0], ctrl_q[DAM_CTRL_RANKS],
						ctrl_q[DAM_CTRL_STACK]);
					decValid_d = 1'b1;
					if (stepHit) begin
						run_d = (run_q == 8'hFF) ? run_q : run_q + 8'h01;
					end else begin
						run_d = 8'h00;
					end
				end
				default: begin
					ctrl_d = ctrl_q;
				end
			endcase
		end
	end

	// state registers
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			waitReq_q <= 1'b1;
			readData_q <= 32'h0;
			ctrl_q <= DAM_CTRL_RST;
			reqAddr_q <= 32'h0;
			fld_q <= '0;
			run_q <= 8'h00;
			decValid_q <= 1'b0;
		end else begin
			waitReq_q <= waitReq_d;
			readData_q <= readData_d;
			ctrl_q <= ctrl_d;
			reqAddr_q <= reqAddr_d;
			fld_q <= fld_d;
			run_q <= run_d;
			decValid_q <= decValid_d;
		end
	end

	assign avs_waitrequest = waitReq_q;
	assign avs_readdata = readData_q;
	assign rowOut = fld_q.row;
	assign colOut = fld_q.col;
	assign bankOut = fld_q.bank;
	assign groupOut = fld_q.grp;
	assign lrankOut = fld_q.lr;
	assign rankOut = fld_q.rank;
	assign decValid = decValid_q;

	// helper for run checks: low bank bit of the previous decode
	logic prevBank0_q;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			prevBank0_q <= 1'b0;
		end else if (decValid_q) begin
			prevBank0_q <= fld_q.bank[0];
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	logic [3:0] ordQ;
	assign ordQ = ctrl_q[3:0];

	AST_BUS_ANSWER: assert property (req && waitReq_q |=> !avs_waitrequest)
		else $error("no answer one cycle after a request");
	AST_RANK_ZERO: assert property (
		decValid && !ctrl_q[DAM_CTRL_RANKS] |-> rankOut == 1'b0)
		else $error("rank not zero in one-rank setup");
	AST_BANK_TOP: assert property (
		decValid && ordQ == DAM_D4_BRC |-> colOut == reqAddr_q[9:0]
		&& rowOut[14:0] == reqAddr_q[24:10] && groupOut == reqAddr_q[28:27])
		else $error("bank-top order mismatch");
	AST_COL_LOW3: assert property (
		decValid && ordQ == DAM_D3_RBC |-> bankOut == reqAddr_q[12:10]
		&& rowOut == reqAddr_q[28:13])
		else $error("older column-low order mismatch");
	AST_COL_LOW4: assert property (
		decValid && ordQ == DAM_D4_RBC |-> bankOut[1:0] == reqAddr_q[11:10]
		&& groupOut == reqAddr_q[13:12] && rowOut[14:0] == reqAddr_q[28:14])
		else $error("newer column-low order mismatch");
	AST_LINEAR: assert property (
		decValid && ordQ == DAM_D4_LIN |-> groupOut == reqAddr_q[4:3]
		&& colOut == {reqAddr_q[13:7], reqAddr_q[2:0]})
		else $error("linear interleave mismatch");
	AST_STACK_LOW: assert property (
		decValid && ordQ == DAM_D4_SDL && ctrl_q[DAM_CTRL_STACK]
		|-> lrankOut == reqAddr_q[7] && colOut[2:0] == reqAddr_q[2:0]
		&& rankOut == (ctrl_q[DAM_CTRL_RANKS] & reqAddr_q[30]))
		else $error("stacked low order mismatch");
	AST_STACK_MID: assert property (
		decValid && ordQ == DAM_D4_SDM && ctrl_q[DAM_CTRL_STACK]
		|-> lrankOut == reqAddr_q[14] && rowOut[14:0] == reqAddr_q[29:15])
		else $error("stacked mid order mismatch");
	AST_HALF3: assert property (
		decValid && ordQ == DAM_D3_HBI |-> bankOut == {reqAddr_q[4:3], reqAddr_q[6]}
		&& colOut[3] == reqAddr_q[5])
		else $error("older half-bank order mismatch");
	AST_HALF16: assert property (
		decValid && ordQ == DAM_D4_HBI16 |-> bankOut[1:0] == {reqAddr_q[6], reqAddr_q[4]}
		&& groupOut[0] == reqAddr_q[3] && colOut[3] == reqAddr_q[5])
		else $error("x16 half-bank order mismatch");
	AST_RUN_FOUR: assert property (
		decValid && ordQ == DAM_D3_HBI && run_q != 8'h00 && reqAddr_q[5:3] != 3'h0
		|-> bankOut[0] == prevBank0_q)
		else $error("run of eight left its four banks");
	AST_LR_ZERO: assert property (
		decValid && !ctrl_q[DAM_CTRL_STACK] |-> lrankOut == 1'b0)
		else $error("logical rank not zero without stacking");
	AST_DEC_PULSE: assert property (
		acc && avs_write && avs_address == DAM_REG_REQ |=> decValid ##1 !decValid)
		else $error("decode pulse not one cycle after accept");
endmodule

/* File: verification/dam_req_model.sv */
// dam_req_model: requester model that issues register accesses as an avalon master
`timescale 1ns/1ps
module dam_req_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// command from the bench
	input wire logic go,
	input wire logic goWr,
	input wire logic [4:0] goAddr,
	input wire logic [31:0] goData,
	input wire logic [3:0] goBe,
	output logic done,
	output logic [31:0] rdata,
	// avalon master side
	output logic [4:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	logic busy = 1'h0;
	logic rdQ = 1'h0;
	logic wrQ = 1'h0;
	logic [4:0] adQ = 5'h1F;
	logic [31:0] wdQ = 32'h0;
	logic [3:0] beQ = 4'hF;
	// request lines come straight from registers so nothing moves between edges
	assign avs_address = adQ;
	assign avs_read = rdQ;
	assign avs_write = wrQ;
	assign avs_writedata = wdQ;
	assign avs_byteenable = beQ;
	initial begin
		done = 1'h0;
		rdata = 32'h0;
	end
	// hold the request until waitrequest is seen low, then take data and release
	always @(posedge clk_sys) begin
		done <= 1'h0;
		if (!nrst) begin
			busy <= 1'h0;
			rdQ <= 1'h0;
			wrQ <= 1'h0;
		end else if (busy && !avs_waitrequest) begin
			busy <= 1'h0;
			rdQ <= 1'h0;
			wrQ <= 1'h0;
			rdata <= avs_readdata;
			done <= 1'h1;
			// released lines show no stale value
			adQ <= ~adQ;
			wdQ <= ~wdQ;
			beQ <= ~beQ;
		end else if (!busy && go) begin
			busy <= 1'h1;
			adQ <= goAddr;
			wdQ <= goData;
			beQ <= goBe;
			wrQ <= goWr;
			rdQ <= !goWr;
		end
	end
endmodule

/* File: verification/test_dam_mapper.sv */
// test_dam_mapper: self-checking bench for the request address mapper
`timescale 1ns/1ps
module test_dam_mapper;
	import dam_pkg::*;
	logic clk_sys, nrst, go, goWr, done, avs_read, avs_write, avs_waitrequest, decValid;
	logic lrankOut, rankOut;
	logic [4:0] goAddr, avs_address;
	logic [31:0] goData, rdata, avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable, goBe;
	logic [15:0] rowOut;
	logic [9:0] colOut;
	logic [2:0] bankOut;
	logic [1:0] groupOut;
	logic [32:0] seenMap;
	int failures = 0;
	int n_tests = 0;
	assign seenMap = {rowOut, colOut, bankOut, groupOut, lrankOut, rankOut};
	dam_req_model u_req (.clk_sys(clk_sys), .nrst(nrst), .go(go), .goWr(goWr),
		.goAddr(goAddr), .goData(goData), .goBe(goBe), .done(done), .rdata(rdata),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	dam_mapper u_dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rowOut(rowOut), .colOut(colOut),
		.bankOut(bankOut), .groupOut(groupOut), .lrankOut(lrankOut), .rankOut(rankOut),
		.decValid(decValid));
	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		n_tests++;
		if (seen !== want) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	// one bus access through the model; returns at the negedge after the accept edge
	task automatic acc_be(input logic wr, input logic [4:0] ad, input logic [31:0] dt,
		input logic [3:0] be);
		int n;
		@(posedge clk_sys);
		go <= 1'h1;
		goWr <= wr;
		goAddr <= ad;
		goData <= dt;
		goBe <= be;
		@(posedge clk_sys);
		go <= 1'h0;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (done !== 1'h1 && n < 50);
		if (n >= 50) begin
			failures++;
			tally_and_finish();
		end
	endtask
	// full-word access, all byte lanes on
	task automatic acc(input logic wr, input logic [4:0] ad, input logic [31:0] dt);
		acc_be(wr, ad, dt, 4'hF);
	endtask
	// reference split: row, col, bank, group, lrank, rank
	function automatic logic [32:0] want_map(logic [31:0] a, logic [3:0] o, logic r2, logic st);
		logic [15:0] row;
		logic [9:0] col;
		logic [2:0] bk;
		logic [1:0] g;
		logic lr, rk;
		row = 16'h0;
		col = 10'h0;
		bk = 3'h0;
		g = 2'h0;
		lr = a[29];
		rk = st ? a[30] : a[29];
		case (o)
			4'h0: begin bk = {a[4:3], a[5]}; col = {a[12:6], a[2:0]}; row = a[28:13]; end
			4'h1: begin col = a[9:0]; row = a[25:10]; bk = a[28:26]; end
			4'h2: begin col = a[9:0]; bk = a[12:10]; row = a[28:13]; end
			4'h3: begin bk = {a[4:3], a[6]}; col = {a[12:7], a[5], a[2:0]}; row = a[28:13]; end
			4'h4: begin g = a[4:3]; bk = {1'h0, a[6:5]}; col = {a[13:7], a[2:0]};
				row = {1'h0, a[28:14]}; end
			4'h5: begin col = a[9:0]; row = {1'h0, a[24:10]}; bk = {1'h0, a[26:25]};
				g = a[28:27]; end
			4'h6: begin col = a[9:0]; bk = {1'h0, a[11:10]}; g = a[13:12];
				row = {1'h0, a[28:14]}; end
			4'h7: begin g = a[4:3]; bk = {1'h0, a[6:5]}; lr = a[7]; col = {a[14:8], a[2:0]};
				row = {1'h0, a[29:15]}; rk = a[30]; end
			4'h8: begin g = a[4:3]; bk = {1'h0, a[6:5]}; col = {a[13:7], a[2:0]}; lr = a[14];
				row = {1'h0, a[29:15]}; rk = a[30]; end
			4'h9: begin g = {1'h0, a[3]}; bk = {1'h0, a[6], a[4]}; col = {a[12:7], a[5], a[2:0]};
				row = {1'h0, a[27:13]}; rk = a[28]; end
			4'hA: begin g = a[4:3]; bk = {1'h0, a[7:6]}; col = {a[13:8], a[5], a[2:0]};
				row = {1'h0, a[28:14]}; end
			default: begin lr = 1'h0; rk = 1'h0; end
		endcase
		if (!r2) rk = 1'h0;
		if (!st) lr = 1'h0;
		return {row, col, bk, g, lr, rk};
	endfunction
	task automatic test_regs();
		acc(1'h0, DAM_REG_CTRL, 32'h0);
		check({1'h0, rdata}, {27'h0, DAM_CTRL_RST});
		check(seenMap, 33'h0);
		acc(1'h1, DAM_REG_CTRL, 32'hFFFF_FFFF);
		acc(1'h0, DAM_REG_CTRL, 32'h0);
		check({1'h0, rdata}, 33'h3F);
		acc(1'h0, 5'h18, 32'h0);
		check({1'h0, rdata}, 33'h0);
		// lanes without enable leave their bytes alone
		acc_be(1'h1, DAM_REG_CTRL, 32'h0, 4'hE);
		acc(1'h0, DAM_REG_CTRL, 32'h0);
		check({1'h0, rdata}, 33'h3F);
		acc_be(1'h1, DAM_REG_REQ, 32'hFFFF_FFFF, 4'h5);
		check(seenMap, 33'h0);
		acc(1'h0, DAM_REG_REQ, 32'h0);
		check({1'h0, rdata}, 33'h00FF_00FF);
		$display("test_regs finished");
	endtask
	// every order code, with and without two ranks; stacking only for codes 4 to 8
	task automatic test_orders();
		logic [31:0] pat [2];
		pat[0] = 32'h6B5C_A3D5;
		pat[1] = 32'h94A3_5C2A;
		for (int o = 0; o < 16; o++) begin
			for (int k = 0; k < 4; k++) begin
				if (k[1] && (o < 4 || o > 8)) continue;
				acc(1'h1, DAM_REG_CTRL, {26'h0, k[1], k[0], o[3:0]});
				for (int p = 0; p < 2; p++) begin
					acc(1'h1, DAM_REG_REQ, pat[p]);
					check({32'h0, decValid}, 33'h1);
					check(seenMap, want_map(pat[p], o[3:0], k[0], k[1]));
					if (o == 4 && k == 3 && p == 0) begin
						// packed field register: bank, group, lrank and rank lanes
						acc(1'h0, DAM_REG_FLD, 32'h0);
						check({1'h0, rdata}, 33'h1122);
					end
				end
			end
		end
		$display("test_orders finished");
	endtask
	// sequential stream in half-bank interleave: banks per run of eight
	task automatic test_run();
		logic [7:0] mask;
		acc(1'h1, DAM_REG_CTRL, 32'h0000_0003);
		acc(1'h1, DAM_REG_REQ, 32'h0000_8100);
		@(negedge clk_sys);
		check({32'h0, decValid}, 33'h0);
		for (int r = 0; r < 2; r++) begin
			mask = 8'h0;
			for (int i = 0; i < 8; i++) begin
				// step of eight from bit 3 up, low bits wander on purpose
				acc(1'h1, DAM_REG_REQ, 32'h0000_4000 + 32'((r * 8 + i) * 8 + i));
				mask[bankOut] = 1'h1;
			end
			check({25'h0, mask}, (r == 1) ? 33'hAA : 33'h55);
		end
		acc(1'h0, DAM_REG_STAT, 32'h0);
		check({1'h0, rdata}, 33'hF);
		// last decode was 0x407F: fields read back over the bus
		acc(1'h0, DAM_REG_ROW, 32'h0);
		check({1'h0, rdata}, 33'h2);
		acc(1'h0, DAM_REG_COL, 32'h0);
		check({1'h0, rdata}, 33'hF);
		acc(1'h0, DAM_REG_FLD, 32'h0);
		check({1'h0, rdata}, 33'h7);
		// field registers only follow request writes
		acc(1'h1, DAM_REG_ROW, 32'hFFFF_FFFF);
		acc(1'h0, DAM_REG_ROW, 32'h0);
		check({1'h0, rdata}, 33'h2);
		$display("test_run finished");
	endtask
	initial begin
		nrst = 1'h0;
		go = 1'h0;
		goWr = 1'h0;
		goAddr = 5'h0;
		goData = 32'h0;
		goBe = 4'hF;
		repeat (12) @(posedge clk_sys);
		nrst <= 1'h1;
		test_regs();
		test_orders();
		test_run();
		tally_and_finish();
	end
endmodule
